// *** design/host_glue_pkg.sv ***
package host_glue_pkg;

    // clock and times
    localparam int CLK_PERIOD_NS = 100;
    localparam int XTAL_KHZ = 16000;
    localparam int HOST_KHZ = 8000;
    localparam int TICK_FAST_NS = 1000000;
    localparam int TICK_SLOW_NS = 2000000;
    localparam int TICK_FAST_CYC = TICK_FAST_NS / CLK_PERIOD_NS;
    localparam int TICK_SLOW_CYC = TICK_SLOW_NS / CLK_PERIOD_NS;
    localparam int MIDI_BAUD = 31250;
    localparam int MIDI_HALF_CYC =
        1000000000 / (MIDI_BAUD * 2 * CLK_PERIOD_NS);
    localparam int TICK_W = 16;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] PEND_OFS = 12'h008;
    localparam logic [11:0] IEN_OFS = 12'h00C;

    // control field positions
    localparam int CTRL_PROG5 = 0;
    localparam int CTRL_PROG6 = 1;
    localparam int CTRL_PROG7 = 2;
    localparam int CTRL_FRONT_MASK_N = 3;
    localparam int CTRL_DIGIO_MASK_N = 4;
    localparam int CTRL_MAP_IN = 5;
    localparam int CTRL_SRAM128 = 6;
    localparam int CTRL_ROM512 = 7;
    localparam int CTRL_W = 8;

    // status field positions
    localparam int STAT_DSP_FLAG = 0;
    localparam int STAT_SLAVE_FLAG = 1;
    localparam int STAT_PWR_FAIL = 2;
    localparam int STAT_LEVEL_LSB = 4;
    localparam int STAT_ANY = 7;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'hFF;

    // interrupt levels
    localparam int IRQ_N = 8;
    localparam int LVL_TIMER = 0;
    localparam int LVL_MIDI = 1;
    localparam int LVL_DISPLAY = 2;
    localparam int LVL_DMA = 3;
    localparam int LVL_DSP = 4;

    // address windows, upper address bits
    localparam logic [1:0] ROM_HI_TAG = 2'h3;
    localparam logic [1:0] ROM_LO_TAG = 2'h1;
    localparam logic [1:0] DRAM_TAG = 2'h0;
    localparam logic [3:0] SRAM_TAG = 4'hB;
    localparam logic [3:0] SRAM_MAP_TAG = 4'h7;
    localparam logic [3:0] CARD_TAG = 4'h8;
    localparam logic [4:0] DSP_TAG = 5'h12;
    localparam logic [6:0] SLAVE_TAG = 7'h50;

    localparam logic [2:0] BUS_PASSIVE = 3'h7;

endpackage

// *** design/mem_select_decode.sv ***
`timescale 1ns/10ps
module mem_select_decode
    import host_glue_pkg::*;
(
    // address and options
    input wire logic [19:0] addr,
    input wire logic rom512,
    input wire logic sram128,
    input wire logic sramMapIn,
    // hits
    output logic romHit,
    output logic dramHit,
    output logic sramDecodeHit,
    output logic dspHit,
    output logic slaveHit,
    output logic cardHit
);
    wire mapWin = sram128 && sramMapIn && addr[19:16] == SRAM_MAP_TAG;
    wire sramSmall = !sram128 && addr[19:15] == {SRAM_TAG, 1'b0};
    wire sramBig = sram128 && addr[19:16] == SRAM_TAG;
    wire romLow = rom512 && addr[19:18] == ROM_LO_TAG && !mapWin;

    assign romHit = addr[19:18] == ROM_HI_TAG || romLow;
    assign dramHit = addr[19:18] == DRAM_TAG;
    assign sramDecodeHit = sramSmall || sramBig || mapWin;
    assign dspHit = addr[19:15] == DSP_TAG;
    assign slaveHit = addr[19:13] == SLAVE_TAG;
    assign cardHit = addr[19:16] == CARD_TAG;
endmodule

// *** design/irq_edge_bank.sv ***
`timescale 1ns/10ps
module irq_edge_bank
    import host_glue_pkg::*;
#(
    parameter int N = IRQ_N
)(
    // clock
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // sources and clears
    input wire logic [N-1:0] src,
    input wire logic [N-1:0] clr,
    // sticky edge flags
    output logic [N-1:0] pending
);
    logic [N-1:0] prev_q;
    logic [N-1:0] pend_q;
    assign pending = pend_q;

    generate
        if (N < 1) begin : g_chk
            $error("irq_edge_bank needs at least one level");
        end
        for (genvar i = 0; i < N; i++) begin : g_lvl
            wire rise = src[i] && !prev_q[i];
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    prev_q[i] <= 1'b0;
                    pend_q[i] <= 1'b0;
                end else if (clkEn) begin
                    prev_q[i] <= src[i];
                    pend_q[i] <= rise || (pend_q[i] && !clr[i]);
                end
            end
        end
    endgenerate
endmodule

// *** design/host_memory_decode_and_irq_glue.sv ***
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
//Contract
// - host phase halves clock; two banks
// - latch muxed address, bits 11:8 direct
// - nmi plus eight levels, level 0 first
// - fixed assignment of sources to levels
// - nmi pulses on receiver error when enabled
// - level 3 from dma terminal count
// - level 4 from slave or dsp
// - dsp flag is line and front mask
// - levels 5-7 from control bits
// - levels respond to rising edges
// - timers give midi clock, 2ms, 1ms
// - rom select for C0000-FFFFF
// - 512K rom also at 40000-7FFFF, less any sram map-in window
// - dram 18 address bits, 10 row, 10 column
// - op delayed to row, preterm to column
// - column select picks high address bits
// - read strobe low means read
// - sram window depends on size, map-in
// - sram enable gated by power monitor
// - dsp port select 90000-97FFF
// - slave ram select A0000-A1FFF
// - card select 80000-8FFFF
module host_memory_decode_and_irq_glue
    import host_glue_pkg::*;
#(
    parameter int FAST_CYC = TICK_FAST_CYC,
    parameter int SLOW_CYC = TICK_SLOW_CYC
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host bus
    input wire logic [19:0] hostAddrBus,
    input wire logic [3:0] hostAddrMid,
    input wire logic addrLatchEn,
    input wire logic [2:0] host_bus_status,
    input wire logic host_mem_read_n,
    input wire logic host_mem_write_n,
    input wire logic host_refresh_req_n,
    output logic [19:0] host_addr_latched,
    // memory selects
    output logic rom_select_n,
    output logic sram_chip_enable_n,
    output logic dsp_port_select_n,
    output logic slave_ram_select_n,
    output logic card_window_select_n,
    // dram
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic column_addr_select,
    output logic [9:0] dram_mux_addr,
    output logic dramWrite_n,
    // interrupt sources
    input wire logic midiEvent,
    input wire logic dma_terminal_count_n,
    input wire logic dsp_port_signal_bit,
    input wire logic slaveIrq,
    input wire logic rxError,
    input wire logic power_fail_monitor,
    // interrupts to processor
    output logic hostNmi,
    output logic [IRQ_N-1:0] prioIrqLevel,
    output logic midiBitClk,
    output logic hostPhase
);
    generate
        if (FAST_CYC < 2 || SLOW_CYC < 2 ||
            FAST_CYC >= 2**TICK_W || SLOW_CYC >= 2**TICK_W) begin : g_chk
            $error("tick counts out of range");
        end
    endgenerate

    // registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [7:0] ien_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic phase_q;
    logic [19:0] addr_q;
    logic rom_q, sram_q, dsp_q, slave_q, card_q;
    logic ras_q, cas_q, colSel_q, dramWr_q;
    logic [9:0] mux_q;
    logic nmi_q, errPrev_q;
    logic [IRQ_N-1:0] irq_q;
    logic [TICK_W-1:0] fast_q, slow_q;
    logic fastTick_q, slowTick_q;
    logic [8:0] midiCnt_q;
    logic midiClk_q;

    // apb decode
    wire setup = psel && !penable;
    wire access = psel && penable && pready_q;
    wire hitCtrl = paddr == CTRL_OFS;
    wire hitStat = paddr == STAT_OFS;
    wire hitPend = paddr == PEND_OFS;
    wire hitIen = paddr == IEN_OFS;
    wire mapped = hitCtrl || hitStat || hitPend || hitIen;
    wire wrCtrl = access && pwrite && hitCtrl;
    wire wrIen = access && pwrite && hitIen;
    wire wrPend = access && pwrite && hitPend;

    // address latch and decode
    wire [19:0] latchNext = addrLatchEn ?
        {hostAddrBus[19:12], hostAddrMid, hostAddrBus[7:0]} :
        {addr_q[19:12], hostAddrMid, addr_q[7:0]};
    wire romHit, dramHit, sramHit, dspHit, slaveHit, cardHit;

    mem_select_decode u_dec (
        .addr(addr_q),
        .rom512(ctrl_q[CTRL_ROM512]),
        .sram128(ctrl_q[CTRL_SRAM128]),
        .sramMapIn(ctrl_q[CTRL_MAP_IN]),
        .romHit(romHit),
        .dramHit(dramHit),
        .sramDecodeHit(sramHit),
        .dspHit(dspHit),
        .slaveHit(slaveHit),
        .cardHit(cardHit)
    );

    // memory cycle qualification
    wire busActive = host_bus_status != BUS_PASSIVE;
    wire memCycle = busActive &&
        (!host_mem_read_n || !host_mem_write_n);
    wire refresh = !host_refresh_req_n;
    wire useSel = memCycle && !refresh;
    wire dram_op_n = !(refresh || (useSel && dramHit));
    wire row_strobe_preterm_n = ras_q || refresh || !memCycle;
    wire isRead = !host_mem_read_n;
    wire sram_decode_hit = useSel && sramHit;
    wire sramEnN = !(sram_decode_hit && !power_fail_monitor);
    wire [9:0] muxNext = colSel_q ? addr_q[19:10] : addr_q[9:0];

    // interrupt sources
    wire dsp_signal_line_n = !dsp_port_signal_bit;
    wire dsp_irq_flag = dsp_signal_line_n &&
        ctrl_q[CTRL_FRONT_MASK_N];
    wire slave_to_host_irq_flag = slaveIrq;
    wire [IRQ_N-1:0] irqSrc = {
        ctrl_q[CTRL_PROG7],
        ctrl_q[CTRL_PROG6],
        ctrl_q[CTRL_PROG5],
        dsp_irq_flag || slave_to_host_irq_flag,
        !dma_terminal_count_n,
        slowTick_q,
        midiEvent,
        fastTick_q
    };
    wire [IRQ_N-1:0] irqClr = wrPend ? pwdata[IRQ_N-1:0] : '0;
    wire [IRQ_N-1:0] pending;

    irq_edge_bank #(.N(IRQ_N)) u_edges (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .src(irqSrc),
        .clr(irqClr),
        .pending(pending)
    );

    // fixed priority, lowest index wins
    wire [IRQ_N-1:0] active = pending & ien_q;
    logic [2:0] topLevel;
    always_comb begin
        topLevel = 3'h0;
        for (int i = IRQ_N - 1; i >= 0; i--) begin
            if (active[i]) begin
                topLevel = 3'(i);
            end
        end
    end
    wire anyActive = |active;
    wire errRise = rxError && !errPrev_q;
    wire nmiNext = errRise && ctrl_q[CTRL_DIGIO_MASK_N];

    // read mux
    wire [7:0] statWord = {anyActive, topLevel, 1'b0,
        power_fail_monitor, slave_to_host_irq_flag, dsp_irq_flag};
    wire [31:0] rdNext =
        hitCtrl ? {24'h000000, ctrl_q} :
        hitStat ? {24'h000000, statWord} :
        hitPend ? {24'h000000, pending} :
        hitIen ? {24'h000000, ien_q} : 32'h00000000;

    // apb slave
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (clkEn) begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            prdata_q <= (setup && !pwrite) ? rdNext : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            ien_q <= IEN_RST;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
            if (wrIen) begin
                ien_q <= pwdata[7:0];
            end
        end
    end

    // host clock phase, halving the core clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else if (clkEn) begin
            phase_q <= !phase_q;
        end
    end

    // address latch follows the strobe every cycle, not only on one phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_q <= 20'h00000;
        end else if (clkEn) begin
            addr_q <= latchNext;
        end
    end

    // bank on host clock: selects, row strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rom_q <= 1'b1;
            sram_q <= 1'b1;
            dsp_q <= 1'b1;
            slave_q <= 1'b1;
            card_q <= 1'b1;
            ras_q <= 1'b1;
            dramWr_q <= 1'b1;
        end else if (clkEn && !phase_q) begin
            rom_q <= !(useSel && romHit);
            sram_q <= sramEnN;
            dsp_q <= !(useSel && dspHit);
            slave_q <= !(useSel && slaveHit);
            card_q <= !(useSel && cardHit);
            ras_q <= dram_op_n;
            dramWr_q <= !(!dram_op_n && !refresh && !isRead);
        end
    end

    // bank on inverted host clock: column side
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cas_q <= 1'b1;
            colSel_q <= 1'b0;
            mux_q <= 10'h000;
        end else if (clkEn && phase_q) begin
            // column strobe falls on the same edge that the mux switches to the column
            cas_q <= row_strobe_preterm_n || !colSel_q;
            colSel_q <= !ras_q && !refresh;
            mux_q <= muxNext;
        end
    end

    // timers and interrupt outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fast_q <= '0;
            slow_q <= '0;
            fastTick_q <= 1'b0;
            slowTick_q <= 1'b0;
            midiCnt_q <= 9'h000;
            midiClk_q <= 1'b0;
        end else if (clkEn) begin
            fastTick_q <= fast_q == TICK_W'(FAST_CYC - 1);
            slowTick_q <= slow_q == TICK_W'(SLOW_CYC - 1);
            fast_q <= (fast_q == TICK_W'(FAST_CYC - 1)) ?
                '0 : fast_q + 1'b1;
            slow_q <= (slow_q == TICK_W'(SLOW_CYC - 1)) ?
                '0 : slow_q + 1'b1;
            if (midiCnt_q == 9'(MIDI_HALF_CYC - 1)) begin
                midiCnt_q <= 9'h000;
                midiClk_q <= !midiClk_q;
            end else begin
                midiCnt_q <= midiCnt_q + 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            errPrev_q <= 1'b0;
            nmi_q <= 1'b0;
            irq_q <= '0;
        end else if (clkEn) begin
            errPrev_q <= rxError;
            nmi_q <= nmiNext;
            irq_q <= anyActive ?
                (IRQ_N'(1) << topLevel) : '0;
        end
    end

    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign host_addr_latched = addr_q;
    assign rom_select_n = rom_q;
    assign sram_chip_enable_n = sram_q;
    assign dsp_port_select_n = dsp_q;
    assign slave_ram_select_n = slave_q;
    assign card_window_select_n = card_q;
    assign row_strobe_n = ras_q;
    assign column_strobe_n = cas_q;
    assign column_addr_select = colSel_q;
    assign dram_mux_addr = mux_q;
    assign dramWrite_n = dramWr_q;
    assign hostNmi = nmi_q;
    assign prioIrqLevel = irq_q;
    assign midiBitClk = midiClk_q;
    assign hostPhase = phase_q;
endmodule

// *** dv/host_glue_props.sv ***
`timescale 1ns/10ps
module host_glue_props
    import host_glue_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // host side
    input wire logic [19:0] host_addr_latched,
    input wire logic host_refresh_req_n,
    input wire logic rxError,
    input wire logic power_fail_monitor,
    // selects and strobes
    input wire logic rom_select_n,
    input wire logic sram_chip_enable_n,
    input wire logic dsp_port_select_n,
    input wire logic slave_ram_select_n,
    input wire logic card_window_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic column_addr_select,
    input wire logic [9:0] dram_mux_addr,
    // interrupts and phase
    input wire logic hostNmi,
    input wire logic [IRQ_N-1:0] prioIrqLevel,
    input wire logic hostPhase
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [19:0] a;
    logic [4:0] sel;
    assign a = host_addr_latched;
    assign sel = ~{rom_select_n, sram_chip_enable_n, dsp_port_select_n,
        slave_ram_select_n, card_window_select_n};
    a_phase_toggle: assert property (
        !$past(rst) |-> hostPhase != $past(hostPhase))
        else $error("host phase stuck");
    a_nmi_pulse: assert property (
        hostNmi |=> !hostNmi) else $error("nmi wider than one cycle");
    a_nmi_cause: assert property (
        $rose(hostNmi) |-> $past(rxError) || $past(rxError, 2))
        else $error("nmi without receiver error");
    a_irq_onehot: assert property (
        $onehot0(prioIrqLevel)) else $error("more than one level");
    a_sel_onehot: assert property (
        $onehot0(sel)) else $error("two selects active");
    a_rom_range: assert property (
        !rom_select_n |-> a[18]) else $error("rom select off range");
    a_dsp_range: assert property (
        !dsp_port_select_n |-> a[19:15] == 5'h12)
        else $error("dsp select off range");
    a_slave_range: assert property (
        !slave_ram_select_n |-> a[19:13] == 7'h50)
        else $error("slave select off range");
    a_card_range: assert property (
        !card_window_select_n |-> a[19:16] == 4'h8)
        else $error("card select off range");
    a_sram_power: assert property (
        power_fail_monitor [*3] |-> sram_chip_enable_n)
        else $error("sram enabled in power fail");
    a_row_dram: assert property (
        $fell(row_strobe_n) |-> a[19:18] == 2'h0 || !host_refresh_req_n)
        else $error("row strobe outside dram");
    a_cas_order: assert property (
        $fell(column_strobe_n) |-> !row_strobe_n && $past(column_addr_select))
        else $error("column strobe out of order");
    a_col_mux: assert property (
        column_addr_select && !column_strobe_n |-> dram_mux_addr == a[19:10])
        else $error("column address wrong");
    cover property ($rose(hostNmi));
    cover property ($fell(column_strobe_n));
    cover property (!sram_chip_enable_n ##1 !sram_chip_enable_n);
endmodule

bind host_memory_decode_and_irq_glue host_glue_props props_u (.*);

// *** dv/host_bus_model.sv ***
`timescale 1ns/10ps
module host_bus_model
    import host_glue_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // request from bench
    input wire logic go,
    input wire logic [19:0] reqAddr,
    input wire logic reqRead,
    output logic busy,
    // host bus pins
    output logic [19:0] hostAddrBus,
    output logic [3:0] hostAddrMid,
    output logic addrLatchEn,
    output logic [2:0] host_bus_status,
    output logic host_mem_read_n,
    output logic host_mem_write_n
);
    logic [3:0] cnt_q;
    logic act;
    assign busy = cnt_q != 4'h0;
    assign act = cnt_q > 4'h3;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            hostAddrBus <= 20'h0;
            hostAddrMid <= 4'h0;
            addrLatchEn <= 1'b0;
            host_bus_status <= BUS_PASSIVE;
            host_mem_read_n <= 1'b1;
            host_mem_write_n <= 1'b1;
        end else if (go && !busy) begin
            // middle bits on the muxed bus are garbage
            cnt_q <= 4'hD;
            addrLatchEn <= 1'b1;
            hostAddrBus <= {reqAddr[19:12], ~reqAddr[11:8], reqAddr[7:0]};
            hostAddrMid <= reqAddr[11:8];
        end else if (busy) begin
            // ten strobe cycles, then three idle; bus carries data
            cnt_q <= cnt_q - 4'h1;
            addrLatchEn <= 1'b0;
            hostAddrBus <= ~hostAddrBus;
            host_bus_status <= act ? 3'h0 : BUS_PASSIVE;
            host_mem_read_n <= !(act && reqRead);
            host_mem_write_n <= !(act && !reqRead);
        end
    end
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench
    import host_glue_pkg::*;
;
    localparam logic [19:0] CORNER [16] = '{20'h3FFFF, 20'h40000,
        20'h6FFFF, 20'h70000, 20'h80000, 20'h8FFFF, 20'h97FFF, 20'h98000,
        20'hA0000, 20'hA1FFF, 20'hA2000, 20'hB7FFF, 20'hB8000, 20'hBFFFF,
        20'hC0000, 20'h00000};
    logic core_clk = 0, rst = 1, clkEn = 1, go = 0, reqRead = 0, busy;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h40BB;
    logic [19:0] hostAddrBus, host_addr_latched, reqAddr = 0;
    logic [3:0] hostAddrMid;
    logic [2:0] host_bus_status;
    logic addrLatchEn, host_mem_read_n, host_mem_write_n;
    logic host_refresh_req_n = 1, midiEvent = 0, slaveIrq = 0, rxError = 0;
    logic dma_terminal_count_n = 1, dsp_port_signal_bit = 1;
    logic power_fail_monitor = 0, hostNmi, midiBitClk, hostPhase;
    logic rom_select_n, sram_chip_enable_n, dsp_port_select_n;
    logic slave_ram_select_n, card_window_select_n, row_strobe_n;
    logic column_strobe_n, column_addr_select, dramWrite_n;
    logic [9:0] dram_mux_addr;
    logic [7:0] prioIrqLevel;
    int errors = 0, total_checks = 0, nmiCnt = 0;

    host_memory_decode_and_irq_glue #(.FAST_CYC(20), .SLOW_CYC(40))
        dut_u (.*);
    host_bus_model bus_u (.*);

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (hostNmi === 1'b1) nmiCnt++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [4:0] expSel(input logic [19:0] a,
        input logic [7:0] c, input logic pf);
        logic win;
        win = c[6] & c[5] & (a[19:16] == 4'h7);
        return {(a[19:18] == 2'h3) | (c[7] & a[19:18] == 2'h1 & !win),
            !pf & ((a[19:15] == 5'h16) | (c[6] & a[19:16] == 4'hB) | win),
            a[19:15] == 5'h12, a[19:13] == 7'h50, a[19:16] == 4'h8};
    endfunction

    task automatic final_report();
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic giveUp();
        errors++;
        final_report();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n == 20) giveUp();
        @(posedge core_clk);
    endtask

    task automatic irqChk(input int k);
        repeat (4) @(posedge core_clk);
        apb(0, PEND_OFS, 0);
        chk(rd & 32'hFA, 32'h1 << k);
        chk(prioIrqLevel, 32'h1 << k);
        apb(1, PEND_OFS, 32'hFF);
        repeat (3) @(posedge core_clk);
        chk(prioIrqLevel, 0);
    endtask

    task automatic mem(input logic [19:0] a, input logic [7:0] c,
        input logic pf);
        logic r;
        logic [4:0] s;
        int n;
        void'(rnd());
        r = seed[0];
        power_fail_monitor <= pf;
        reqAddr <= a;
        reqRead <= r;
        go <= 1;
        @(posedge core_clk);
        go <= 0;
        repeat (7) @(posedge core_clk);
        chk(host_addr_latched, a);
        s = ~{rom_select_n, sram_chip_enable_n, dsp_port_select_n,
            slave_ram_select_n, card_window_select_n};
        chk(s, expSel(a, c, pf));
        if (a[19:18] == 2'h0)
            chk({row_strobe_n, column_strobe_n, dramWrite_n}, r);
        else
            chk(row_strobe_n, 1);
        n = 0;
        while (busy !== 1'b0 && n < 30) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 30) giveUp();
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        giveUp();
    end

    initial begin
        logic [31:0] r;
        logic [7:0] c;
        int n0;
        repeat (6) @(posedge core_clk);
        rst <= 0;
        chk({rom_select_n, row_strobe_n, hostNmi, prioIrqLevel}, 11'h600);
        @(posedge core_clk);
        apb(0, CTRL_OFS, 0);
        chk(rd, 0);
        apb(0, IEN_OFS, 0);
        chk(rd, 32'hFF);
        apb(1, 12'h010, 32'h5A);
        chk(err, 1);
        apb(1, STAT_OFS, 32'hFF);
        chk(err, 0);
        apb(1, IEN_OFS, 32'hFA);
        apb(1, CTRL_OFS, 32'h18);
        apb(1, PEND_OFS, 32'hFF);
        midiEvent <= 1;
        irqChk(1);
        midiEvent <= 0;
        dma_terminal_count_n <= 0;
        irqChk(3);
        dma_terminal_count_n <= 1;
        dsp_port_signal_bit <= 0;
        irqChk(4);
        apb(0, STAT_OFS, 0);
        chk(rd[1:0], 1);
        apb(1, CTRL_OFS, 32'h10);
        apb(0, STAT_OFS, 0);
        chk(rd[1:0], 0);
        dsp_port_signal_bit <= 1;
        apb(1, CTRL_OFS, 32'h18);
        slaveIrq <= 1;
        irqChk(4);
        apb(0, STAT_OFS, 0);
        chk(rd[1:0], 2);
        slaveIrq <= 0;
        for (int k = 5; k < 8; k++) begin
            apb(1, CTRL_OFS, 32'h18 | (1 << (k - 5)));
            irqChk(k);
            apb(1, CTRL_OFS, 32'h18);
        end
        apb(1, CTRL_OFS, 32'h1D);
        repeat (4) @(posedge core_clk);
        chk(prioIrqLevel, 32'h20);
        apb(1, IEN_OFS, 32'hFF);
        repeat (50) @(posedge core_clk);
        apb(0, PEND_OFS, 0);
        chk(rd & 32'h5, 32'h5);
        apb(1, IEN_OFS, 32'hFA);
        for (int m = 0; m < 2; m++) begin
            n0 = nmiCnt;
            apb(1, CTRL_OFS, m ? 32'h08 : 32'h18);
            rxError <= 1;
            repeat (3) @(posedge core_clk);
            rxError <= 0;
            repeat (3) @(posedge core_clk);
            chk(nmiCnt - n0, 1 - m);
        end
        for (int i = 0; i < 48; i++) begin
            r = rnd();
            c = {r[7:6], 1'b0, 5'h18};
            apb(1, CTRL_OFS, {24'h0, c});
            mem(i < 16 ? CORNER[i] : r[31:12], c, r[10:8] == 3'h0);
        end
        host_refresh_req_n <= 0;
        repeat (5) @(posedge core_clk);
        chk({row_strobe_n, column_strobe_n}, 2'b01);
        host_refresh_req_n <= 1;
        repeat (5) @(posedge core_clk);
        final_report();
    end
endmodule
